// *** adcc_defines.svh ***
`ifndef ADCC_DEFINES_SVH
`define ADCC_DEFINES_SVH

// Field reset values
`define ADCC_CLKSEL_RESET 2'h3
`define ADCC_PINSEL_RESET 2'h3
`define ADCC_CHSEL_RESET 2'h0

// Clock select codes
`define ADCC_CLKSEL_DIV16 2'h0
`define ADCC_CLKSEL_DIV8 2'h1
`define ADCC_CLKSEL_DIV4 2'h2
`define ADCC_CLKSEL_OSC4 2'h3

// Divisors, as terminal counts of a 4-bit prescaler
`define ADCC_DIV16_LAST 4'hF
`define ADCC_DIV8_LAST 4'h7
`define ADCC_DIV4_LAST 4'h3

// Conversion length in conversion clock periods
`define ADCC_CONV_PERIODS 4'hD

`endif

// *** adcc_pkg.sv ***
package adcc_pkg;
  typedef enum logic [0:0] {
    ADCC_IDLE = 1'b0,
    ADCC_CONV = 1'b1
  } adcc_state_type;
endpackage

// *** adcc_divider.sv ***
`timescale 1ns/1ps
`include "adcc_defines.svh"
module adcc_divider
  import adcc_pkg::*;
(
  // Clock and hold
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic hold_i,
  // Selected divisor terminal count
  input wire logic [3:0] last_i,
  // One-cycle conversion clock tick
  output logic tick_o
);
  logic [3:0] cnt_q;

  // Held in reset outside a conversion
  always_ff @(posedge clk_i) begin
    if (rst_i || hold_i) begin
      cnt_q <= 4'h0;
    end else if (cnt_q == last_i) begin
      cnt_q <= 4'h0;
    end else begin
      cnt_q <= cnt_q + 4'h1;
    end
  end

  assign tick_o = !hold_i && (cnt_q == last_i);
endmodule

// *** adcc_top.sv ***
// Notes on behaviour
// - Four clock settings: /16, /8, /4, osc/4
// - Conversion lasts exactly 13 clock periods at /16, /8, /4; at osc/4 the first period can be short
// - Conversion clock divided from instruction clock, except osc/4, which uses the oscillator tick
// - Clock select change waits next conversion
// - Clock select resets and wakes to 11
// - Pin select resets to 11, all analog
// - Analog pins lose digital output drive
// - Comparator one output overrides pin two
// - Pin configuration ignores converter-on bit
// - Channel change waits for conversion end
// - Sleep entry discards channel selection
// - Go starts; hardware clears it when done
// - Clearing go aborts, partial result kept
// - Sleep clears go and halts conversion
// - Go ignored while converter is off
// - Each conversion yields an 8-bit result
`timescale 1ns/1ps
`include "adcc_defines.svh"
module adcc_top
  import adcc_pkg::*;
(
  // Clock and reset
  input wire logic CLK_I,
  input wire logic RST_I,
  // Power state
  input wire logic SLEEP_ENTER_I,
  input wire logic WAKE_I,
  // Control writes
  input wire logic CONV_CLOCK_SELECT_WE_I,
  input wire logic [1:0] CONV_CLOCK_SELECT_I,
  input wire logic ANALOG_PIN_SELECT_WE_I,
  input wire logic [1:0] ANALOG_PIN_SELECT_I,
  input wire logic CHANNEL_SELECT_WE_I,
  input wire logic [1:0] CHANNEL_SELECT_I,
  input wire logic CONVERTER_ON_I,
  input wire logic GO_WE_I,
  input wire logic GO_I,
  // Internal oscillator divided by four, as a one-cycle enable
  input wire logic OSC_DIV4_TICK_I,
  // Comparator one
  input wire logic COMPARATOR_ONE_OUTPUT_I,
  input wire logic COMPARATOR_ONE_OUTEN_I,
  // Converter core: one result bit per step, MSB first
  input wire logic CORE_BIT_I,
  // Port digital output enables requested by software
  input wire logic [2:0] PORT_OUT_EN_I,
  input wire logic [2:0] PORT_OUT_I,
  // Status and settings
  output logic GO_DONE_O,
  output logic [1:0] CONV_CLOCK_SELECT_O,
  output logic [1:0] ANALOG_PIN_SELECT_O,
  output logic [1:0] CHANNEL_SELECT_O,
  output logic [1:0] ACTIVE_CHANNEL_O,
  output logic [7:0] CONVERSION_RESULT_O,
  output logic [3:0] CONV_STEP_O,
  // Pin drive
  output logic [2:0] PIN_OUT_O,
  output logic [2:0] PIN_OE_O,
  output logic [2:0] PIN_ANALOG_O
);
  adcc_state_type state_q;
  logic [1:0] clksel_q;
  logic [1:0] run_clksel_q;
  logic [1:0] pinsel_q;
  logic [1:0] chsel_q;
  logic [1:0] run_ch_q;
  logic [3:0] step_q;
  logic [7:0] result_q;
  logic [3:0] div_last;
  logic div_tick;
  logic conv_tick;
  logic hold;
  logic start;
  logic abort;
  logic finish;
  logic div_clear;
  logic [2:0] analog_mask;

  assign start = (state_q == ADCC_IDLE) && GO_WE_I && GO_I && CONVERTER_ON_I
                 && !SLEEP_ENTER_I;
  assign abort = (state_q == ADCC_CONV) && (SLEEP_ENTER_I || (GO_WE_I && !GO_I));
  assign hold = (state_q != ADCC_CONV);

  always_comb begin
    case (run_clksel_q)
      `ADCC_CLKSEL_DIV16: div_last = `ADCC_DIV16_LAST;
      `ADCC_CLKSEL_DIV8: div_last = `ADCC_DIV8_LAST;
      `ADCC_CLKSEL_DIV4: div_last = `ADCC_DIV4_LAST;
      default: div_last = `ADCC_DIV4_LAST;
    endcase
  end

  adcc_divider u_div (
    .clk_i(CLK_I),
    .rst_i(div_clear),
    .hold_i(hold),
    .last_i(div_last),
    .tick_o(div_tick)
  );

  assign conv_tick = (run_clksel_q == `ADCC_CLKSEL_OSC4) ? (OSC_DIV4_TICK_I && !hold)
                                                         : div_tick;
  assign finish = (state_q == ADCC_CONV) && conv_tick && !abort
                  && (step_q == `ADCC_CONV_PERIODS - 4'h1);
  // Clear on the ending edge so no count survives into idle
  assign div_clear = RST_I || abort || finish;

  always_ff @(posedge CLK_I) begin
    if (RST_I || WAKE_I) begin
      clksel_q <= `ADCC_CLKSEL_RESET;
    end else if (CONV_CLOCK_SELECT_WE_I) begin
      clksel_q <= CONV_CLOCK_SELECT_I;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      pinsel_q <= `ADCC_PINSEL_RESET;
    end else if (ANALOG_PIN_SELECT_WE_I) begin
      pinsel_q <= ANALOG_PIN_SELECT_I;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RST_I || SLEEP_ENTER_I) begin
      chsel_q <= `ADCC_CHSEL_RESET;
    end else if (CHANNEL_SELECT_WE_I) begin
      chsel_q <= CHANNEL_SELECT_I;
    end
  end

  // Settings latched at start so mid-conversion writes wait
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      run_clksel_q <= `ADCC_CLKSEL_RESET;
      run_ch_q <= `ADCC_CHSEL_RESET;
    end else if (start) begin
      run_clksel_q <= clksel_q;
      run_ch_q <= chsel_q;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      state_q <= ADCC_IDLE;
    end else begin
      case (state_q)
        ADCC_IDLE: if (start) state_q <= ADCC_CONV;
        ADCC_CONV: if (abort || finish) state_q <= ADCC_IDLE;
        default: state_q <= ADCC_IDLE;
      endcase
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RST_I || hold || abort || finish) begin
      step_q <= 4'h0;
    end else if (conv_tick) begin
      step_q <= step_q + 4'h1;
    end
  end

  // Steps 1..8 shift in result bits; partial value stays on abort
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      result_q <= 8'h00;
    end else if (start) begin
      result_q <= 8'h00;
    end else if (conv_tick && !abort && step_q >= 4'h1 && step_q <= 4'h8) begin
      result_q <= {result_q[6:0], CORE_BIT_I};
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      CONVERSION_RESULT_O <= 8'h00;
    end else if (finish || abort) begin
      CONVERSION_RESULT_O <= result_q;
    end
  end

  always_comb begin
    case (pinsel_q)
      2'h0: analog_mask = 3'h0;
      2'h1: analog_mask = 3'h1;
      2'h2: analog_mask = 3'h3;
      default: analog_mask = 3'h7;
    endcase
  end

  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_pin
      if (g == 2) begin : g_cmp
        assign PIN_OE_O[g] = COMPARATOR_ONE_OUTEN_I ||
                             (PORT_OUT_EN_I[g] && !analog_mask[g]);
        assign PIN_OUT_O[g] = COMPARATOR_ONE_OUTEN_I ? COMPARATOR_ONE_OUTPUT_I
                                                     : PORT_OUT_I[g];
        assign PIN_ANALOG_O[g] = analog_mask[g] && !COMPARATOR_ONE_OUTEN_I;
      end else begin : g_plain
        assign PIN_OE_O[g] = PORT_OUT_EN_I[g] && !analog_mask[g];
        assign PIN_OUT_O[g] = PORT_OUT_I[g];
        assign PIN_ANALOG_O[g] = analog_mask[g];
      end
    end
  endgenerate

  assign GO_DONE_O = (state_q == ADCC_CONV);
  assign CONV_CLOCK_SELECT_O = clksel_q;
  assign ANALOG_PIN_SELECT_O = pinsel_q;
  assign CHANNEL_SELECT_O = chsel_q;
  assign ACTIVE_CHANNEL_O = (state_q == ADCC_CONV) ? run_ch_q : chsel_q;
  assign CONV_STEP_O = step_q;

  sequence s_started;
    start;
  endsequence
  sequence s_busy_no_abort;
    (GO_DONE_O && !abort) [*2];
  endsequence

  chk_go_blocked_off: assert property (@(posedge CLK_I) disable iff (RST_I)
    (!GO_DONE_O && !CONVERTER_ON_I) |=> !GO_DONE_O)
    else $error("go set while converter off");
  chk_go_set_start: assert property (@(posedge CLK_I) disable iff (RST_I)
    s_started |=> GO_DONE_O)
    else $error("go write did not start a conversion");
  chk_abort_stops: assert property (@(posedge CLK_I) disable iff (RST_I)
    abort |=> (!GO_DONE_O && CONV_STEP_O == 4'h0))
    else $error("abort did not stop conversion");
  chk_sleep_clears: assert property (@(posedge CLK_I) disable iff (RST_I)
    SLEEP_ENTER_I |=> (!GO_DONE_O && CHANNEL_SELECT_O == `ADCC_CHSEL_RESET))
    else $error("sleep did not clear go and channel");
  chk_done_result: assert property (@(posedge CLK_I) disable iff (RST_I)
    finish |=> (!GO_DONE_O && CONVERSION_RESULT_O == $past(result_q)))
    else $error("result not written at done");
  // Divide by four: 13 periods of 4 cycles, go falls on the 53rd cycle
  chk_thirteen_ticks: assert property (@(posedge CLK_I) disable iff (RST_I || abort)
    (start && clksel_q == `ADCC_CLKSEL_DIV4) |-> ##52 GO_DONE_O ##1 !GO_DONE_O)
    else $error("conversion length not thirteen periods");
  chk_idle_held: assert property (@(posedge CLK_I) disable iff (RST_I)
    !GO_DONE_O |-> (CONV_STEP_O == 4'h0))
    else $error("counter moved while idle");
  chk_clksel_held: assert property (@(posedge CLK_I) disable iff (RST_I)
    s_busy_no_abort |-> $stable(run_clksel_q))
    else $error("clock source changed mid conversion");
  chk_channel_held: assert property (@(posedge CLK_I) disable iff (RST_I)
    s_busy_no_abort |-> $stable(ACTIVE_CHANNEL_O))
    else $error("channel changed mid conversion");
  chk_analog_no_out: assert property (@(posedge CLK_I) disable iff (RST_I)
    (analog_mask[0] |-> !PIN_OE_O[0]))
    else $error("analog pin drives digital");
  chk_div16_tick: assert property (@(posedge CLK_I) disable iff (RST_I || abort)
    (start && clksel_q == `ADCC_CLKSEL_DIV16) |=>
    (!conv_tick [*8] ##1 !conv_tick [*7] ##1 conv_tick))
    else $error("divide by sixteen ticked early");
endmodule

// *** adcc_core_model.sv ***
`timescale 1ns/1ps
module adcc_core_model (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Converter state
  input wire logic busy_i,
  input wire logic [1:0] channel_i,
  // Result bit to the control block
  output logic bit_o
);
  logic junk_q;
  always_ff @(posedge clk_i) begin
    junk_q <= rst_i ? 1'b0 : ~junk_q;
  end
  // Odd-parity channels read full scale, others zero; line toggles when idle
  assign bit_o = busy_i ? ^channel_i : junk_q;
endmodule

// *** adc_conversion_control_bench.sv ***
`timescale 1ns/1ps
module adc_conversion_control_bench;
  import adcc_pkg::*;
  logic CLK_I = 1'b0;
  logic RST_I = 1'b1;
  logic SLP = 1'b0, WAK = 1'b0, ON = 1'b1, GWE = 1'b0, GV = 1'b0, OSC = 1'b0;
  logic CMO = 1'b0, CME = 1'b0, CORE_BIT, GO_DONE_O;
  logic [2:0] we = 3'h0, PEN = 3'h0, POU = 3'h0, PIN_OUT_O, PIN_OE_O, PIN_ANALOG_O, an, oe;
  logic [1:0] wv [3] = '{2'h0, 2'h0, 2'h0};
  logic [1:0] CLKSEL_O, PINSEL_O, CHSEL_O, ACT_CH;
  logic [7:0] RES_O;
  logic [3:0] STEP_O;
  logic [31:0] rnd = 32'h2BCB;
  int fail_count = 0, checks_done = 0, cycles = 0, n, ch;
  int m_set [3] = '{3, 3, 0};
  int divs [$] = '{16, 8, 4, 4};

  adcc_top dut_u (.CLK_I(CLK_I), .RST_I(RST_I), .SLEEP_ENTER_I(SLP), .WAKE_I(WAK),
    .CONV_CLOCK_SELECT_WE_I(we[0]), .CONV_CLOCK_SELECT_I(wv[0]),
    .ANALOG_PIN_SELECT_WE_I(we[1]), .ANALOG_PIN_SELECT_I(wv[1]),
    .CHANNEL_SELECT_WE_I(we[2]), .CHANNEL_SELECT_I(wv[2]), .CONVERTER_ON_I(ON),
    .GO_WE_I(GWE), .GO_I(GV), .OSC_DIV4_TICK_I(OSC), .COMPARATOR_ONE_OUTPUT_I(CMO),
    .COMPARATOR_ONE_OUTEN_I(CME), .CORE_BIT_I(CORE_BIT), .PORT_OUT_EN_I(PEN),
    .PORT_OUT_I(POU), .GO_DONE_O(GO_DONE_O), .CONV_CLOCK_SELECT_O(CLKSEL_O),
    .ANALOG_PIN_SELECT_O(PINSEL_O), .CHANNEL_SELECT_O(CHSEL_O), .ACTIVE_CHANNEL_O(ACT_CH),
    .CONVERSION_RESULT_O(RES_O), .CONV_STEP_O(STEP_O), .PIN_OUT_O(PIN_OUT_O),
    .PIN_OE_O(PIN_OE_O), .PIN_ANALOG_O(PIN_ANALOG_O));
  adcc_core_model core_u (.clk_i(CLK_I), .rst_i(RST_I), .busy_i(GO_DONE_O),
    .channel_i(ACT_CH), .bit_o(CORE_BIT));

  always #50 CLK_I = ~CLK_I;
  always @(posedge CLK_I) begin
    cycles <= cycles + 1;
    OSC <= (cycles % 4 == 3);
    if (cycles == 20000) begin
      fail_count = fail_count + 1;
      complete_run;
    end
  end

  function automatic logic [31:0] xs(logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  task automatic cmp(string what, logic [7:0] seen, logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic cmp_len(string what, int seen, int exp);
    checks_done++;
    if (seen != exp) begin
      fail_count++;
      $display("[ERR] %s expected %0d seen %0d", what, exp, seen);
    end
  endtask
  task automatic wr(int f, logic [1:0] v);
    @(posedge CLK_I) we[f] <= 1'b1;
    wv[f] <= v;
    @(posedge CLK_I) we[f] <= 1'b0;
    m_set[f] = v;
  endtask
  task automatic go(logic v);
    @(posedge CLK_I) GWE <= 1'b1;
    GV <= v;
    @(posedge CLK_I) GWE <= 1'b0;
  endtask
  // Counts cycles with go high, ends on the first low sample
  task automatic wait_done;
    n = 0;
    @(negedge CLK_I);
    while (GO_DONE_O === 1'b1 && n < 400) begin
      n++;
      @(negedge CLK_I);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  initial begin
    repeat (4) @(posedge CLK_I);
    RST_I <= 1'b0;
    @(negedge CLK_I);
    cmp("go", GO_DONE_O, 8'h00);
    cmp("clock select", CLKSEL_O, 8'h03);
    cmp("pin select", PINSEL_O, 8'h03);
    cmp("result", RES_O, 8'h00);
    $display("test reset done");
    for (int c = 0; c < 4; c++) begin
      ch = c ^ (c < 2);
      wr(0, 2'(c));
      wr(2, 2'(ch));
      go(1'b1);
      wait_done;
      if (c < 3) cmp_len("length", n, 13 * divs[c]);
      else cmp_len("osc length", (n >= 48 && n <= 53), 1);
      cmp("result", RES_O, (ch == 1 || ch == 2) ? 8'hFF : 8'h00);
      cmp("step idle", STEP_O, 8'h00);
    end
    $display("test divisors done");
    wr(0, 2'h2);
    wr(2, 2'h1);
    go(1'b1);
    wr(0, 2'h0);
    wr(2, 2'h0);
    wait_done;
    cmp_len("length", n, 48);
    cmp("result", RES_O, 8'hFF);
    cmp("channel", CHSEL_O, 8'(m_set[2]));
    go(1'b1);
    repeat (40) @(posedge CLK_I);
    go(1'b0);
    @(negedge CLK_I);
    cmp("go abort", GO_DONE_O, 8'h00);
    cmp("step abort", STEP_O, 8'h00);
    cmp("result abort", RES_O, 8'h00);
    cmp("clock keep", CLKSEL_O, 8'(m_set[0]));
    @(posedge CLK_I) ON <= 1'b0;
    go(1'b1);
    @(negedge CLK_I);
    cmp("go off", GO_DONE_O, 8'h00);
    @(posedge CLK_I) ON <= 1'b1;
    wr(2, 2'h1);
    go(1'b1);
    repeat (5) @(posedge CLK_I);
    SLP <= 1'b1;
    @(posedge CLK_I) SLP <= 1'b0;
    m_set[2] = 0;
    @(negedge CLK_I);
    cmp("go sleep", GO_DONE_O, 8'h00);
    cmp("channel sleep", CHSEL_O, 8'(m_set[2]));
    @(posedge CLK_I) WAK <= 1'b1;
    @(posedge CLK_I) WAK <= 1'b0;
    @(negedge CLK_I);
    cmp("clock wake", CLKSEL_O, 8'h03);
    $display("test control done");
    for (int p = 0; p < 4; p++) begin
      wr(1, 2'(p));
      an = 3'((1 << p) - 1);
      repeat (4) begin
        rnd = xs(rnd);
        @(posedge CLK_I) {CMO, CME, ON, POU, PEN} <= rnd[8:0];
        @(negedge CLK_I);
        oe = PEN & ~an;
        if (CME) oe[2] = 1'b1;
        cmp("pin oe", PIN_OE_O, oe);
        cmp("pin out", PIN_OUT_O & oe, (CME ? {CMO, POU[1:0]} : POU) & oe);
        cmp("pin analog", PIN_ANALOG_O, {an[2] & ~CME, an[1:0]});
      end
    end
    $display("test pins done");
    complete_run;
  end
endmodule
